// ==== hdl/frame_suspend_pkg.sv ====
/*
  Types shared by the frame timer and suspend controller.
  Assumes the constants header is included where numbers are needed.
*/
package frame_suspend_pkg;
  typedef enum logic [2:0] {
    pwr_run,
    pwr_armed,
    pwr_suspended,
    pwr_waking,
    pwr_remote_k
  } pwr_state_t;
endpackage : frame_suspend_pkg

// ==== hdl/frame_suspend_regs.svh ====
/*
  Holds the field positions, clock rate and timing counts of the frame
  timer and suspend logic. Assumes a 12 MHz internal bit clock ratio is
  represented by the 100 MHz system clock given below.
*/
`ifndef FRAME_SUSPEND_REGS_SVH
`define FRAME_SUSPEND_REGS_SVH

// clock rate in kHz
`define CLK_KHZ                100000
// frame interval and tolerances, in internal clocks
`define FRAME_NOMINAL          14'h2ee0
`define FRAME_TOLERANCE        14'h002d
`define FRAME_JITTER           14'h0002
`define LOCK_SOF_COUNT         2'h3
`define SYNTH_FRAME_MAX        2'h3
// times in ms
`define SUSPEND_IDLE_MS        3
`define RESUME_MAX_MS          15
`define REMOTE_K_MS            12
`define SUSPEND_IDLE_CYCLES    (`SUSPEND_IDLE_MS * `CLK_KHZ)
`define RESUME_MAX_CYCLES      (`RESUME_MAX_MS * `CLK_KHZ)
`define REMOTE_K_CYCLES        (`REMOTE_K_MS * `CLK_KHZ)
// clock stabilisation wait, in cycles
`define CLK_STABLE_CYCLES      4096
// frame count high register: lock flag position
`define FRAME_LOCK_BIT         7
// system status register field positions
`define SSR_RESET_BIT          0
`define SSR_SUSPEND_BIT        1
`define SSR_RESUME_BIT         2

`endif

// ==== hdl/usb_suspend_resume_frame_timer.sv ====
/*
  Frame timer locking to start-of-frame packets, and suspend/resume
  sequencing with bus reset status. Assumes the packet engine gives a
  one-cycle sof_valid pulse and line-state levels from the bus pins;
  controller bits arrive as plain ports synchronous to clk except
  remote_wake_n, bus_j_state and bus_k_state, which are synchronised here.
*/
// Functional notes
// - lock after three valid frame packets
// - interval within 45 of 12000, jitter two
// - synthesize up to three missing frames
// - drop lock on resets, suspend, misses, violations
// - idle J 3 ms means suspend
// - suspend sets flag, interrupts if enabled
// - suspend flag stays set while suspended
// - clear of suspend bit stops clocks
// - host K or remote wake starts wake-up
// - stable clocks then run, flag resume
// - full function within 15 ms
// - remote wake drives K 12 ms
// - suspend lock blocks floating register strobes
// - bus reset sets reset flag, interrupts
`include "frame_suspend_regs.svh"

module usb_suspend_resume_frame_timer #(
  parameter int IDLE_CYCLES   = `SUSPEND_IDLE_CYCLES,
  parameter int K_CYCLES      = `REMOTE_K_CYCLES,
  parameter int STABLE_CYCLES = `CLK_STABLE_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // bus events
  input  wire logic       sof_valid,
  input  wire logic       bus_reset,
  input  wire logic       bus_j_state,
  input  wire logic       bus_k_state,
  output logic            drive_k,
  // controller bits
  input  wire logic       soft_reset,
  input  wire logic       frame_irq_enable,
  input  wire logic       frame_pulse_disable,
  input  wire logic       suspend_detect_disable,
  input  wire logic       suspend_irq_enable,
  input  wire logic       bus_reset_irq_enable,
  input  wire logic       suspend_ctrl,
  input  wire logic       write_pending_hold,
  input  wire logic       suspend_lock_enable,
  input  wire logic       clear_synth_frame,
  input  wire logic       clear_reset_flag,
  input  wire logic       clear_resume_flag,
  // status
  output logic            frame_lock_flag,
  output logic            synth_frame_flag,
  output logic            suspend_flag,
  output logic            resume_flag,
  output logic            reset_flag,
  output logic            clocks_enabled,
  output logic            reg_write_lock,
  output logic [13:0]     last_interval,
  // pins
  input  wire logic       remote_wake_n,
  output logic            frame_pulse_n,
  output logic            suspended_n,
  output logic            interrupt_n
);

  logic [1:0]  sync_j;
  logic [1:0]  sync_k;
  logic [1:0]  sync_rw;
  logic        line_j;
  logic        line_k;
  logic        wake_req;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_j  <= 2'h0;
      sync_k  <= 2'h0;
      sync_rw <= 2'h3;
    end else begin
      sync_j  <= {sync_j[0], bus_j_state};
      sync_k  <= {sync_k[0], bus_k_state};
      sync_rw <= {sync_rw[0], remote_wake_n};
    end
  end
  assign line_j   = sync_j[1];
  assign line_k   = sync_k[1];
  assign wake_req = line_k | ~sync_rw[1];

  // frame timer
  logic [13:0] frame_cnt;
  logic [13:0] prev_interval;
  logic [1:0]  good_cnt;
  logic [1:0]  miss_cnt;
  logic        have_prev;
  logic        have_interval;
  logic        frame_pulse;
  frame_suspend_pkg::pwr_state_t pwr;

  wire [13:0] lo_lim   = `FRAME_NOMINAL - `FRAME_TOLERANCE;
  wire [13:0] hi_lim   = `FRAME_NOMINAL + `FRAME_TOLERANCE;
  wire [13:0] diff_int = (frame_cnt > prev_interval) ? frame_cnt - prev_interval : prev_interval - frame_cnt;
  wire        in_window = (frame_cnt >= lo_lim) && (frame_cnt <= hi_lim);
  wire        jitter_ok = !have_interval || (diff_int <= `FRAME_JITTER);
  wire        sof_good  = have_prev && in_window && jitter_ok;
  // frame overdue once the latest legal packet time passes unseen
  wire        frame_end = frame_cnt == hi_lim;
  wire        in_suspend = (pwr == frame_suspend_pkg::pwr_suspended) || (pwr == frame_suspend_pkg::pwr_waking);
  wire        unlock = soft_reset || bus_reset || in_suspend || (sof_valid && !sof_good && have_prev)
                       || (frame_lock_flag && frame_end && !sof_valid && miss_cnt == `SYNTH_FRAME_MAX);
  wire        synth_tick = frame_lock_flag && frame_end && !sof_valid && miss_cnt != `SYNTH_FRAME_MAX;
  // counter holds the interval so far; a synthesized frame restarts as if on time
  wire [13:0] next_frame_cnt = sof_valid ? 14'h0001
                               : (frame_lock_flag && frame_end) ? `FRAME_TOLERANCE + 14'h0001
                               : frame_cnt + 14'h0001;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frame_cnt     <= 14'h0000;
      prev_interval <= 14'h0000;
      have_prev     <= 1'b0;
      have_interval <= 1'b0;
      good_cnt      <= 2'h0;
      miss_cnt      <= 2'h0;
      frame_lock_flag <= 1'b0;
      last_interval <= 14'h0000;
    end else begin
      frame_cnt <= next_frame_cnt;
      if (sof_valid) begin
        have_prev    <= 1'b1;
        miss_cnt     <= 2'h0;
        last_interval <= frame_cnt;
        if (sof_good) begin
          prev_interval <= frame_cnt;
          have_interval <= 1'b1;
        end
      end else if (synth_tick) begin
        miss_cnt <= miss_cnt + 2'h1;
      end
      if (unlock) begin
        frame_lock_flag <= 1'b0;
        good_cnt        <= 2'h0;
        have_interval   <= 1'b0;
        if (!sof_valid)
          have_prev <= 1'b0;
        miss_cnt <= 2'h0;
      end else if (sof_valid && sof_good && !frame_lock_flag) begin
        good_cnt <= good_cnt + 2'h1;
        if (good_cnt + 2'h1 == `LOCK_SOF_COUNT)
          frame_lock_flag <= 1'b1;
      end
    end
  end

  // counting from the first packet: the third good one needs a prior reference
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      synth_frame_flag <= 1'b0;
      frame_pulse      <= 1'b0;
    end else begin
      frame_pulse <= (sof_valid || synth_tick) && !frame_pulse_disable;
      if (synth_tick)
        synth_frame_flag <= 1'b1;
      else if (clear_synth_frame)
        synth_frame_flag <= 1'b0;
    end
  end
  assign frame_pulse_n = ~frame_pulse;

  // suspend and resume sequencing
  logic [31:0] idle_cnt;
  logic [31:0] seq_cnt;
  logic [31:0] wake_cnt;
  logic        susp_ctrl_q;
  logic        remote_wake;

  wire suspend_detect = !suspend_detect_disable && line_j && idle_cnt == IDLE_CYCLES - 1
                        && pwr == frame_suspend_pkg::pwr_run;
  wire commit = susp_ctrl_q && !suspend_ctrl && pwr == frame_suspend_pkg::pwr_armed && suspend_flag;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      idle_cnt    <= 32'h0;
      susp_ctrl_q <= 1'b0;
    end else begin
      susp_ctrl_q <= suspend_ctrl;
      idle_cnt    <= (line_j && idle_cnt != IDLE_CYCLES - 1) ? idle_cnt + 32'h1 : (line_j ? idle_cnt : 32'h0);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pwr         <= frame_suspend_pkg::pwr_run;
      seq_cnt     <= 32'h0;
      remote_wake <= 1'b0;
      wake_cnt    <= 32'h0;
    end else begin
      wake_cnt <= (pwr == frame_suspend_pkg::pwr_waking) ? wake_cnt + 32'h1 : 32'h0;
      case (pwr)
        frame_suspend_pkg::pwr_run: begin
          if (suspend_detect)
            pwr <= frame_suspend_pkg::pwr_armed;
        end
        frame_suspend_pkg::pwr_armed: begin
          if (!line_j || bus_reset)
            pwr <= frame_suspend_pkg::pwr_run;
          else if (commit)
            pwr <= frame_suspend_pkg::pwr_suspended;
        end
        frame_suspend_pkg::pwr_suspended: begin
          // wake on host K or remote wake
          if (wake_req) begin
            pwr         <= frame_suspend_pkg::pwr_waking;
            remote_wake <= !line_k;
            seq_cnt     <= 32'h0;
          end
        end
        frame_suspend_pkg::pwr_waking: begin
          seq_cnt <= seq_cnt + 32'h1;
          if (seq_cnt == STABLE_CYCLES - 1) begin
            seq_cnt <= 32'h0;
            pwr     <= remote_wake ? frame_suspend_pkg::pwr_remote_k : frame_suspend_pkg::pwr_run;
          end
        end
        frame_suspend_pkg::pwr_remote_k: begin
          // K for the full remote wake time
          seq_cnt <= seq_cnt + 32'h1;
          if (seq_cnt == K_CYCLES - 1)
            pwr <= frame_suspend_pkg::pwr_run;
        end
        default: pwr <= frame_suspend_pkg::pwr_run;
      endcase
    end
  end

  wire resume_done = pwr == frame_suspend_pkg::pwr_waking && seq_cnt == STABLE_CYCLES - 1;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      suspend_flag <= 1'b0;
      resume_flag  <= 1'b0;
      reset_flag   <= 1'b0;
    end else begin
      // held until resume or bus activity
      if (suspend_detect)
        suspend_flag <= 1'b1;
      else if (resume_done || (pwr == frame_suspend_pkg::pwr_armed && !line_j))
        suspend_flag <= 1'b0;
      if (resume_done)
        resume_flag <= 1'b1;
      else if (clear_resume_flag)
        resume_flag <= 1'b0;
      if (bus_reset)
        reset_flag <= 1'b1;
      else if (clear_reset_flag)
        reset_flag <= 1'b0;
    end
  end

  assign clocks_enabled = !in_suspend;
  assign suspended_n    = !in_suspend;
  assign drive_k        = pwr == frame_suspend_pkg::pwr_remote_k;
  // block strobes after suspend when locking enabled or write_pending_hold is low
  assign reg_write_lock = in_suspend && (suspend_lock_enable || !write_pending_hold);

  assign interrupt_n = !((synth_frame_flag && frame_irq_enable)
                       || ((suspend_flag || resume_flag) && suspend_irq_enable)
                       || (reset_flag && bus_reset_irq_enable));

  a_lock_needs_three: assert property (@(posedge clk) disable iff (reset)
    $rose(frame_lock_flag) |-> $past(sof_valid) && $past(good_cnt) == 2'h2)
    else $error("lock without third good frame");
  a_unlock_on_reset: assert property (@(posedge clk) disable iff (reset)
    bus_reset |=> !frame_lock_flag)
    else $error("lock kept over bus reset");
  a_synth_flag_set: assert property (@(posedge clk) disable iff (reset)
    synth_tick |=> synth_frame_flag)
    else $error("synthesized frame not flagged");
  a_suspend_flag_set: assert property (@(posedge clk) disable iff (reset)
    suspend_detect |=> suspend_flag && pwr == frame_suspend_pkg::pwr_armed)
    else $error("suspend not flagged");
  a_flag_held_susp: assert property (@(posedge clk) disable iff (reset)
    pwr == frame_suspend_pkg::pwr_suspended |-> suspend_flag)
    else $error("suspend flag lost while suspended");
  a_commit_gates_clk: assert property (@(posedge clk) disable iff (reset)
    commit |=> !suspended_n && !clocks_enabled)
    else $error("commit did not suspend");
  a_wake_start: assert property (@(posedge clk) disable iff (reset)
    pwr == frame_suspend_pkg::pwr_suspended && wake_req |=> pwr == frame_suspend_pkg::pwr_waking)
    else $error("wake request ignored");
  a_resume_flagged: assert property (@(posedge clk) disable iff (reset)
    resume_done |=> resume_flag && suspended_n)
    else $error("resume not flagged");
  a_reset_flagged: assert property (@(posedge clk) disable iff (reset)
    bus_reset |=> reset_flag)
    else $error("bus reset not flagged");
  a_irq_reset: assert property (@(posedge clk) disable iff (reset)
    reset_flag && bus_reset_irq_enable |-> !interrupt_n)
    else $error("interrupt not raised");
  a_resume_bound: assert property (@(posedge clk) disable iff (reset)
    pwr == frame_suspend_pkg::pwr_waking |-> wake_cnt < `RESUME_MAX_CYCLES)
    else $error("resume took too long");

  c_lock: cover property (@(posedge clk) disable iff (reset) $rose(frame_lock_flag));
  c_synth: cover property (@(posedge clk) disable iff (reset) synth_tick);
  c_suspend: cover property (@(posedge clk) disable iff (reset) commit);
  c_remote: cover property (@(posedge clk) disable iff (reset) $rose(drive_k));

endmodule : usb_suspend_resume_frame_timer

// ==== verification/usb_host_model.sv ====
/*
  Host side of the bus: frame packets, line state and bus reset.
  Assumes one clk domain; the bench calls the tasks just after an edge.
*/
module usb_host_model (
  // clock
  input  wire logic clk,
  // device drives K on remote wake
  input  wire logic drive_k,
  // bus
  output logic      sof_valid,
  output logic      bus_reset,
  output logic      bus_j_state,
  output logic      bus_k_state
);
  timeunit 1ns;
  timeprecision 1ns;
  logic idle_j = 1'b0;
  logic wake_k = 1'b0;
  logic tgl = 1'b0;
  initial sof_valid = 1'b0;
  initial bus_reset = 1'b0;
  // traffic toggles every cycle, so no stale level is held
  always @(posedge clk) tgl <= ~tgl;
  assign bus_k_state = wake_k | drive_k | (~idle_j & ~tgl);
  assign bus_j_state = ~bus_k_state & (idle_j | tgl);
  task automatic sof_after(input int n);
    repeat (n - 1) @(posedge clk);
    #1 sof_valid = 1'b1;
    @(posedge clk);
    #1 sof_valid = 1'b0;
  endtask : sof_after
  task automatic line(input logic j, input logic k);
    idle_j = j;
    wake_k = k;
  endtask : line
  task automatic pulse_reset();
    bus_reset = 1'b1;
    @(posedge clk);
    #1 bus_reset = 1'b0;
  endtask : pulse_reset
endmodule : usb_host_model

// ==== verification/usb_suspend_resume_frame_timer_tb.sv ====
/*
  Bench for the frame timer and suspend logic: frame rows, synthesis,
  reset, suspend and both wake paths, bus reset.
  Assumes the host model stands on the bus side.
*/
module usb_suspend_resume_frame_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int IDLE = 20;
  localparam int KC = 10;
  localparam int STB = 8;
  typedef struct {int gap; logic lock;} row_t;
  row_t rows [3] = '{'{12000, 1'b0}, '{12002, 1'b0}, '{12001, 1'b1}};
  logic clk = 1'b0, reset = 1'b1, sof_valid, bus_reset, bus_j_state, bus_k_state, drive_k;
  logic soft_reset = 1'b0, frame_irq_enable = 1'b0, frame_pulse_disable = 1'b0;
  logic suspend_detect_disable = 1'b1, suspend_irq_enable = 1'b1, bus_reset_irq_enable = 1'b1;
  logic suspend_ctrl = 1'b0, write_pending_hold = 1'b0, suspend_lock_enable = 1'b0;
  logic clear_synth_frame = 1'b0, clear_reset_flag = 1'b0, clear_resume_flag = 1'b0;
  logic frame_lock_flag, synth_frame_flag, suspend_flag, resume_flag, reset_flag;
  logic clocks_enabled, reg_write_lock, remote_wake_n = 1'b1;
  logic frame_pulse_n, suspended_n, interrupt_n;
  logic [13:0] last_interval;
  logic [13:0] pulses = 14'h0, kcnt = 14'h0;
  int mismatches = 0, num_checks = 0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (frame_pulse_n === 1'b0) pulses <= pulses + 14'h1;
    if (drive_k === 1'b1) kcnt <= kcnt + 14'h1;
  end
  usb_host_model i_usb_host_model (.clk(clk), .drive_k(drive_k), .sof_valid(sof_valid),
    .bus_reset(bus_reset), .bus_j_state(bus_j_state), .bus_k_state(bus_k_state));
  usb_suspend_resume_frame_timer #(.IDLE_CYCLES(IDLE), .K_CYCLES(KC), .STABLE_CYCLES(STB))
    i_usb_suspend_resume_frame_timer (.clk(clk), .reset(reset), .sof_valid(sof_valid),
    .bus_reset(bus_reset), .bus_j_state(bus_j_state), .bus_k_state(bus_k_state), .drive_k(drive_k),
    .soft_reset(soft_reset), .frame_irq_enable(frame_irq_enable),
    .frame_pulse_disable(frame_pulse_disable), .suspend_detect_disable(suspend_detect_disable),
    .suspend_irq_enable(suspend_irq_enable), .bus_reset_irq_enable(bus_reset_irq_enable),
    .suspend_ctrl(suspend_ctrl), .write_pending_hold(write_pending_hold),
    .suspend_lock_enable(suspend_lock_enable), .clear_synth_frame(clear_synth_frame),
    .clear_reset_flag(clear_reset_flag), .clear_resume_flag(clear_resume_flag),
    .frame_lock_flag(frame_lock_flag), .synth_frame_flag(synth_frame_flag),
    .suspend_flag(suspend_flag), .resume_flag(resume_flag), .reset_flag(reset_flag),
    .clocks_enabled(clocks_enabled), .reg_write_lock(reg_write_lock),
    .last_interval(last_interval), .remote_wake_n(remote_wake_n),
    .frame_pulse_n(frame_pulse_n), .suspended_n(suspended_n), .interrupt_n(interrupt_n));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : chk
  task automatic chk14(input string nm, input logic [13:0] e, input logic [13:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk14
  task automatic strobe(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(2);
  endtask : strobe
  // bounded wait for a level
  task automatic wait_for(ref logic s, input logic v);
    for (int i = 0; i < 60 && s !== v; i++) tick(1);
  endtask : wait_for
  task automatic commit();
    write_pending_hold = 1'b1;
    suspend_ctrl = 1'b1;
    tick(2);
    suspend_ctrl = 1'b0;
    tick(3);
  endtask : commit
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    test_done();
  end
  initial begin
    tick(3);
    reset = 1'b0;
    tick(3);
    i_usb_host_model.sof_after(100);
    foreach (rows[r]) begin
      i_usb_host_model.sof_after(rows[r].gap);
      chk14("last_interval", 14'(rows[r].gap), last_interval);
      chk("frame_lock_flag", rows[r].lock, frame_lock_flag);
    end
    frame_irq_enable = 1'b1;
    tick(12200);
    chk("synth_frame_flag", 1'b1, synth_frame_flag);
    chk("interrupt_n", 1'b0, interrupt_n);
    tick(24000);
    chk("frame_lock_flag", 1'b1, frame_lock_flag);
    tick(12000);
    chk("frame_lock_flag", 1'b0, frame_lock_flag);
    chk14("pulses", 14'h7, pulses);
    strobe(clear_synth_frame);
    chk("interrupt_n", 1'b1, interrupt_n);
    reset = 1'b1;
    tick(1);
    chk("synth_frame_flag", 1'b0, synth_frame_flag);
    chk("suspended_n", 1'b1, suspended_n);
    chk("frame_pulse_n", 1'b1, frame_pulse_n);
    reset = 1'b0;
    tick(3);
    frame_pulse_disable = 1'b1;
    i_usb_host_model.sof_after(5);
    chk("frame_pulse_n", 1'b1, frame_pulse_n);
    frame_pulse_disable = 1'b0;
    i_usb_host_model.sof_after(5);
    chk("frame_pulse_n", 1'b0, frame_pulse_n);
    i_usb_host_model.line(1'b1, 1'b0);
    tick(60);
    chk("suspend_flag", 1'b0, suspend_flag);
    i_usb_host_model.line(1'b0, 1'b0);
    suspend_detect_disable = 1'b0;
    tick(2);
    i_usb_host_model.line(1'b1, 1'b0);
    tick(15);
    chk("suspend_flag", 1'b0, suspend_flag);
    wait_for(suspend_flag, 1'b1);
    chk("suspend_flag", 1'b1, suspend_flag);
    chk("interrupt_n", 1'b0, interrupt_n);
    i_usb_host_model.line(1'b0, 1'b0);
    tick(6);
    chk("suspend_flag", 1'b0, suspend_flag);
    i_usb_host_model.line(1'b1, 1'b0);
    wait_for(suspend_flag, 1'b1);
    suspend_lock_enable = 1'b1;
    commit();
    chk("suspended_n", 1'b0, suspended_n);
    chk("clocks_enabled", 1'b0, clocks_enabled);
    chk("reg_write_lock", 1'b1, reg_write_lock);
    tick(20);
    chk("suspend_flag", 1'b1, suspend_flag);
    i_usb_host_model.line(1'b0, 1'b1);
    wait_for(suspended_n, 1'b1);
    chk("suspended_n", 1'b1, suspended_n);
    chk("resume_flag", 1'b1, resume_flag);
    chk("clocks_enabled", 1'b1, clocks_enabled);
    chk("drive_k", 1'b0, drive_k);
    i_usb_host_model.line(1'b0, 1'b0);
    strobe(clear_resume_flag);
    chk("interrupt_n", 1'b1, interrupt_n);
    write_pending_hold = 1'b0;
    suspend_lock_enable = 1'b0;
    i_usb_host_model.line(1'b1, 1'b0);
    wait_for(suspend_flag, 1'b1);
    commit();
    chk("reg_write_lock", 1'b0, reg_write_lock);
    remote_wake_n = 1'b0;
    tick(3);
    remote_wake_n = 1'b1;
    wait_for(suspended_n, 1'b1);
    chk("suspended_n", 1'b1, suspended_n);
    i_usb_host_model.line(1'b0, 1'b0);
    tick(KC + 10);
    chk14("kcnt", 14'(KC), kcnt);
    strobe(clear_resume_flag);
    write_pending_hold = 1'b0;
    i_usb_host_model.pulse_reset();
    tick(2);
    chk("reset_flag", 1'b1, reset_flag);
    chk("interrupt_n", 1'b0, interrupt_n);
    strobe(clear_reset_flag);
    chk("interrupt_n", 1'b1, interrupt_n);
    test_done();
  end
endmodule : usb_suspend_resume_frame_timer_tb
